// File: src/cfsc_pkg.sv
// Package with the register map, field layout and bus carrier of the frame statistics counters.
package cfsc_pkg;

    // ========================================================================
    // Bus geometry
    // ========================================================================
    localparam int CFSC_ADR_W = 12;
    localparam int CFSC_DAT_W = 32;
    localparam int CFSC_IDX_W = 10;
    localparam int CFSC_CNT_W = 16;
    localparam int CFSC_NCH   = 2;

    // ========================================================================
    // Register indices; the byte address is four times the index
    // ========================================================================
    localparam logic [CFSC_IDX_W-1:0] CFSC_IDX_UP_HIGH   = 10'h26F;
    localparam logic [CFSC_IDX_W-1:0] CFSC_IDX_UP_LOW    = 10'h270;
    localparam logic [CFSC_IDX_W-1:0] CFSC_IDX_HOST_HIGH = 10'h271;
    localparam logic [CFSC_IDX_W-1:0] CFSC_IDX_HOST_LOW  = 10'h272;
    localparam logic [CFSC_IDX_W-1:0] CFSC_IDX_UP_SNAP   = 10'h280;
    localparam logic [CFSC_IDX_W-1:0] CFSC_IDX_HOST_SNAP = 10'h281;
    localparam logic [CFSC_IDX_W-1:0] CFSC_IDX_SAT       = 10'h282;
    localparam logic [CFSC_IDX_W-1:0] CFSC_IDX_ENABLE    = 10'h283;

    // ========================================================================
    // Field layout and reset values
    // ========================================================================
    localparam int CFSC_UP_CH   = 0;
    localparam int CFSC_HOST_CH = 1;
    localparam logic [CFSC_CNT_W-1:0] CFSC_CNT_RESET = 16'h0000;
    localparam logic [CFSC_CNT_W-1:0] CFSC_CNT_MAX   = 16'hFFFF;
    localparam logic [CFSC_NCH-1:0]   CFSC_EN_RESET  = 2'h3;
    localparam logic [CFSC_DAT_W-1:0] CFSC_RD_ZERO   = 32'h0000_0000;

    // ========================================================================
    // Classic Wishbone request from the master
    // ========================================================================
    typedef struct packed {
        logic                  cyc;
        logic                  stb;
        logic                  we;
        logic [CFSC_ADR_W-1:0] adr;
        logic [3:0]            sel;
        logic [CFSC_DAT_W-1:0] dat;
    } cfsc_wb_req_t;

endpackage

// File: src/cfsc_counter.sv
// Saturating frame counter with a latched snapshot and byte-wise clear on read.
`timescale 1ns/1ps
module cfsc_counter
    import cfsc_pkg::*;
#(
    parameter int CNT_W = CFSC_CNT_W
) (
    input  wire logic             ref_clk,
    input  wire logic             rst_n,
    input  wire logic             count_en,
    input  wire logic             frame_evt,
    input  wire logic             snap_req,
    input  wire logic             clr_high,
    input  wire logic             clr_low,
    output logic [CNT_W-1:0]      shadow_q,
    output logic                  saturated_q
);

    logic [CNT_W-1:0] live_q;
    logic [CNT_W-1:0] live_d;
    logic             live_clr;
    logic             inc;

    assign live_clr = snap_req | clr_high | clr_low;
    assign inc      = count_en & frame_evt;

    // A frame in the clearing cycle opens the new interval, so it is not lost.
    always_comb begin
        if (live_clr) begin
            live_d = inc ? CNT_W'(1) : CNT_W'(CFSC_CNT_RESET);
        end else if (inc && live_q != {CNT_W{1'b1}}) begin
            live_d = live_q + CNT_W'(1);
        end else begin
            live_d = live_q;
        end
    end

    // ========================================================================
    // Live count: saturates at all ones, restarts on snapshot or byte read
    // ========================================================================
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            live_q <= CNT_W'(CFSC_CNT_RESET);
        end else begin
            live_q <= live_d;
        end
    end

    // ========================================================================
    // Shadow: loaded on snapshot, each byte cleared when it is read
    // ========================================================================
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            shadow_q <= CNT_W'(CFSC_CNT_RESET);
        end else if (snap_req) begin
            shadow_q <= live_q;
        end else begin
            if (clr_high) begin
                shadow_q[CNT_W-1:8] <= '0;
            end
            if (clr_low) begin
                shadow_q[7:0] <= 8'h00;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            saturated_q <= 1'b0;
        end else begin
            saturated_q <= (live_q == {CNT_W{1'b1}});
        end
    end

endmodule

// File: src/cfsc_top.sv
// Frame statistics counters for the upper stack port and the host port, on classic Wishbone.
//
// Summary of operation
// - Count valid response frames from the upper stack port; low byte at index 0x270.
// - The upper-port count stops at 0xFFFF instead of wrapping.
// - Reading the upper-port low byte clears that byte and restarts the counter.
// - Reading the upper-port snapshot register latches all upper-port statistics together.
// - Count response frames sent on the host port; high byte at index 0x271.
// - The host-port count saturates at all ones (printed limit taken as 0xFFFF).
// - Reading the host-port high byte clears that byte and restarts the counter.
// - Reading the host-port snapshot register latches all host-port statistics together.
// - Host-port low byte at index 0x272 pairs with the high byte, resets to zero.
// - Upper-port high byte at index 0x26F pairs with the low byte, resets to zero.
`timescale 1ns/1ps
module cfsc_top
    import cfsc_pkg::*;
(
    input  wire logic                  ref_clk,
    input  wire logic                  rst_n,
    input  wire cfsc_wb_req_t          wb_req,
    output logic [CFSC_DAT_W-1:0]      wb_dat_o,
    output logic                       wb_ack_o,
    input  wire logic                  upper_valid_frame_evt,
    input  wire logic                  host_tx_frame_evt
);

    // ========================================================================
    // Bus access decode
    // ========================================================================
    logic [CFSC_DAT_W-1:0] wb_dat_q;
    logic [CFSC_DAT_W-1:0] rd_data;
    logic                  wb_ack_q;
    logic                  access;
    logic                  rd_access;
    logic                  wr_access;
    logic [CFSC_IDX_W-1:0] idx;
    logic [CFSC_NCH-1:0]   count_en_q;
    logic [CFSC_NCH-1:0]   frame_evt;
    logic [CFSC_NCH-1:0]   snap_req;
    logic [CFSC_NCH-1:0]   clr_high;
    logic [CFSC_NCH-1:0]   clr_low;
    logic [CFSC_NCH-1:0]   saturated;
    logic [CFSC_CNT_W-1:0] shadow [CFSC_NCH];

    localparam logic [CFSC_IDX_W-1:0] HIGH_IDX [CFSC_NCH] =
        '{CFSC_IDX_UP_HIGH, CFSC_IDX_HOST_HIGH};
    localparam logic [CFSC_IDX_W-1:0] LOW_IDX [CFSC_NCH] =
        '{CFSC_IDX_UP_LOW, CFSC_IDX_HOST_LOW};
    localparam logic [CFSC_IDX_W-1:0] SNAP_IDX [CFSC_NCH] =
        '{CFSC_IDX_UP_SNAP, CFSC_IDX_HOST_SNAP};

    // An access takes effect once, in the cycle its acknowledge is registered.
    assign access    = wb_req.cyc & wb_req.stb & ~wb_ack_q;
    assign rd_access = access & ~wb_req.we;
    assign wr_access = access & wb_req.we;
    assign idx       = wb_req.adr[CFSC_ADR_W-1:2];

    assign frame_evt[CFSC_UP_CH]   = upper_valid_frame_evt;
    assign frame_evt[CFSC_HOST_CH] = host_tx_frame_evt;

    // ========================================================================
    // Counter channels
    // ========================================================================
    generate
        for (genvar ch = 0; ch < CFSC_NCH; ch++) begin : g_ch
            // Read side effects fire only on reads with the low byte lane selected.
            assign snap_req[ch] = rd_access & wb_req.sel[0] && idx == SNAP_IDX[ch];
            assign clr_high[ch] = rd_access & wb_req.sel[0] && idx == HIGH_IDX[ch];
            assign clr_low[ch]  = rd_access & wb_req.sel[0] && idx == LOW_IDX[ch];

            cfsc_counter #(
                .CNT_W (CFSC_CNT_W)
            ) u_counter (
                .ref_clk     (ref_clk),
                .rst_n       (rst_n),
                .count_en    (count_en_q[ch]),
                .frame_evt   (frame_evt[ch]),
                .snap_req    (snap_req[ch]),
                .clr_high    (clr_high[ch]),
                .clr_low     (clr_low[ch]),
                .shadow_q    (shadow[ch]),
                .saturated_q (saturated[ch])
            );
        end
    endgenerate

    // ========================================================================
    // Read multiplexer
    // ========================================================================
    always_comb begin
        rd_data = CFSC_RD_ZERO;
        case (idx)
            CFSC_IDX_UP_HIGH: begin
                rd_data[7:0] = shadow[CFSC_UP_CH][15:8];
            end
            CFSC_IDX_UP_LOW: begin
                rd_data[7:0] = shadow[CFSC_UP_CH][7:0];
            end
            CFSC_IDX_HOST_HIGH: begin
                rd_data[7:0] = shadow[CFSC_HOST_CH][15:8];
            end
            CFSC_IDX_HOST_LOW: begin
                rd_data[7:0] = shadow[CFSC_HOST_CH][7:0];
            end
            CFSC_IDX_SAT: begin
                rd_data[CFSC_NCH-1:0] = saturated;
            end
            CFSC_IDX_ENABLE: begin
                rd_data[CFSC_NCH-1:0] = count_en_q;
            end
            default: begin
                rd_data = CFSC_RD_ZERO;
            end
        endcase
    end

    // ========================================================================
    // Wishbone answer: one wait state, acknowledge held for one cycle
    // ========================================================================
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            wb_ack_q <= 1'b0;
        end else begin
            wb_ack_q <= access;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            wb_dat_q <= CFSC_RD_ZERO;
        end else if (rd_access) begin
            wb_dat_q <= rd_data;
        end
    end

    // ========================================================================
    // Count enable register
    // ========================================================================
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            count_en_q <= CFSC_EN_RESET;
        end else if (wr_access && wb_req.sel[0] && idx == CFSC_IDX_ENABLE) begin
            count_en_q <= wb_req.dat[CFSC_NCH-1:0];
        end
    end

    assign wb_dat_o = wb_dat_q;
    assign wb_ack_o = wb_ack_q;

endmodule

// File: testbench/cfsc_monitor.sv
// Checker for bus timing and clear-on-read behaviour of the statistics counters.
`timescale 1ns/1ps
module cfsc_monitor
    import cfsc_pkg::*;
(
    input wire logic                  ref_clk,
    input wire logic                  rst_n,
    input wire cfsc_wb_req_t          wb_req,
    input wire logic [CFSC_DAT_W-1:0] wb_dat_o,
    input wire logic                  wb_ack_o,
    input wire logic                  upper_valid_frame_evt,
    input wire logic                  host_tx_frame_evt
);
    logic [CFSC_IDX_W-1:0] idx;
    logic                  take;
    logic                  rd;
    logic                  byte_hit;
    logic                  mapped;
    logic [1:0]            bsel;
    logic [3:0]            clr_q;
    assign idx      = wb_req.adr[11:2];
    assign take     = wb_req.cyc && wb_req.stb && !wb_ack_o;
    assign rd       = take && !wb_req.we;
    assign byte_hit = idx >= CFSC_IDX_UP_HIGH && idx <= CFSC_IDX_HOST_LOW;
    assign bsel     = 2'(idx - CFSC_IDX_UP_HIGH);
    assign mapped   = byte_hit || (idx >= CFSC_IDX_UP_SNAP && idx <= CFSC_IDX_ENABLE);
    // A set flag marks a byte known to be zero; a snapshot makes its content unknown.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            clr_q <= 4'hF;
        end else if (rd && wb_req.sel[0]) begin
            if (byte_hit) clr_q[bsel] <= 1'b1;
            if (idx == CFSC_IDX_UP_SNAP) clr_q[1:0] <= 2'h0;
            if (idx == CFSC_IDX_HOST_SNAP) clr_q[3:2] <= 2'h0;
        end
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    ack_timing_a: assert property (take |=> wb_ack_o) else $error("ack late");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
    ack_cause_a: assert property (wb_ack_o |-> $past(take))
        else $error("spurious ack");
    rd_clear_a: assert property (rd && byte_hit && clr_q[bsel]
        |=> wb_dat_o == CFSC_RD_ZERO) else $error("cleared byte not zero");
    snap_zero_a: assert property (rd &&
        (idx == CFSC_IDX_UP_SNAP || idx == CFSC_IDX_HOST_SNAP) |=> wb_dat_o == CFSC_RD_ZERO)
        else $error("snapshot read not zero");
    unmapped_zero_a: assert property (rd && !mapped |=> wb_dat_o == CFSC_RD_ZERO)
        else $error("unmapped read not zero");
    byte_width_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
        else $error("upper data bits set");
    dat_hold_a: assert property (!$past(rd) |-> $stable(wb_dat_o))
        else $error("data moved");
    cover property (rd && idx == CFSC_IDX_UP_SNAP);
    cover property (rd && idx == CFSC_IDX_SAT);
    cover property (upper_valid_frame_evt && host_tx_frame_evt);
endmodule
bind cfsc_top cfsc_monitor i_mon (.ref_clk(ref_clk), .rst_n(rst_n), .wb_req(wb_req),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .upper_valid_frame_evt(upper_valid_frame_evt),
    .host_tx_frame_evt(host_tx_frame_evt));

// File: testbench/cfsc_host_model.sv
// Bus master standing in for the host controller that reads the statistics.
`timescale 1ns/1ps
module cfsc_host_model
    import cfsc_pkg::*;
(
    input  wire logic ref_clk,
    input  wire logic wb_ack_o,
    output cfsc_wb_req_t wb_req
);
    initial wb_req = '0;
    // One classic cycle: the request is held until ack is sampled, then idles a cycle.
    task automatic access(input logic we, input logic [CFSC_IDX_W-1:0] ix,
                          input logic [CFSC_DAT_W-1:0] wd);
        @(posedge ref_clk);
        wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: {ix, 2'b00}, sel: 4'hF, dat: wd};
        do @(posedge ref_clk); while (wb_ack_o !== 1'b1);
        wb_req <= '0;
        @(posedge ref_clk);
    endtask
endmodule

// File: testbench/cfsc_top_tb.sv
// Self-checking bench for the frame statistics counters.
`timescale 1ns/1ps
module cfsc_top_tb
    import cfsc_pkg::*;
;
    logic                  ref_clk  = 1'b0;
    logic                  rst_n    = 1'b0;
    logic                  up_evt   = 1'b0;
    logic                  host_evt = 1'b0;
    cfsc_wb_req_t          wb_req;
    logic [CFSC_DAT_W-1:0] wb_dat_o;
    logic                  wb_ack_o;
    logic [CFSC_DAT_W-1:0] exp_q[$];
    int                    mismatches = 0;
    int                    n_compared = 0;
    int                    cycles     = 0;
    int                    n_up;
    int                    n_host;
    always #2 ref_clk = ~ref_clk;
    cfsc_top i_dut (.ref_clk(ref_clk), .rst_n(rst_n), .wb_req(wb_req), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .upper_valid_frame_evt(up_evt), .host_tx_frame_evt(host_evt));
    cfsc_host_model i_host (.ref_clk(ref_clk), .wb_ack_o(wb_ack_o), .wb_req(wb_req));
    task automatic conclude();
        $display("compared %0d, mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic check(string nm, logic [31:0] got, logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic rd(logic [CFSC_IDX_W-1:0] ix, logic [CFSC_DAT_W-1:0] ex);
        exp_q.push_back(ex);
        i_host.access(1'b0, ix, '0);
    endtask
    task automatic pulses(int nu, int nh);
        for (int i = 0; i < nu || i < nh; i++) begin
            @(posedge ref_clk);
            up_evt   <= (i < nu);
            host_evt <= (i < nh);
        end
        @(posedge ref_clk);
        up_evt   <= 1'b0;
        host_evt <= 1'b0;
    endtask
    // Watcher: every read ack takes the oldest expected value.
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (wb_ack_o === 1'b1 && wb_req.we === 1'b0 && exp_q.size() > 0)
            check("read data", wb_dat_o, exp_q.pop_front());
        if (cycles > 80000) begin
            mismatches++;
            conclude();
        end
    end
    initial begin
        void'($urandom(32'hBDF5CA81));
        n_up   = $urandom_range(700, 1);
        n_host = $urandom_range(700, 1);
        repeat (16) @(posedge ref_clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 4; i++) rd(10'(CFSC_IDX_UP_HIGH + i), 32'h0);
        pulses(n_up, n_host);
        rd(CFSC_IDX_UP_SNAP, 32'h0);
        rd(CFSC_IDX_UP_HIGH, 32'(n_up[15:8]));
        rd(CFSC_IDX_UP_LOW, 32'(n_up[7:0]));
        rd(CFSC_IDX_UP_LOW, 32'h0);
        rd(CFSC_IDX_HOST_SNAP, 32'h0);
        rd(CFSC_IDX_HOST_HIGH, 32'(n_host[15:8]));
        rd(CFSC_IDX_HOST_HIGH, 32'h0);
        rd(CFSC_IDX_HOST_LOW, 32'(n_host[7:0]));
        i_host.access(1'b1, CFSC_IDX_UP_LOW, 32'h0000_00A5);
        rd(CFSC_IDX_UP_LOW, 32'h0);
        rd(10'h3A5, 32'h0);
        // With upper counting disabled, only the host channel advances.
        i_host.access(1'b1, CFSC_IDX_ENABLE, 32'h0000_0002);
        rd(CFSC_IDX_ENABLE, 32'h2);
        pulses(3, 3);
        rd(CFSC_IDX_UP_SNAP, 32'h0);
        rd(CFSC_IDX_UP_LOW, 32'h0);
        i_host.access(1'b1, CFSC_IDX_ENABLE, 32'h0000_0003);
        rd(CFSC_IDX_ENABLE, 32'h3);
        // A byte read restarts the live count, so only the later frames are latched.
        pulses(4, 0);
        rd(CFSC_IDX_UP_LOW, 32'h0);
        pulses(5, 0);
        rd(CFSC_IDX_UP_SNAP, 32'h0);
        rd(CFSC_IDX_UP_LOW, 32'h5);
        pulses(65537, 65537);
        rd(CFSC_IDX_SAT, 32'h3);
        rd(CFSC_IDX_UP_SNAP, 32'h0);
        rd(CFSC_IDX_UP_HIGH, 32'hFF);
        rd(CFSC_IDX_UP_LOW, 32'hFF);
        rd(CFSC_IDX_HOST_SNAP, 32'h0);
        rd(CFSC_IDX_HOST_HIGH, 32'hFF);
        rd(CFSC_IDX_HOST_LOW, 32'hFF);
        repeat (4) @(posedge ref_clk);
        conclude();
    end
endmodule
